// ==== src/tmw_mode_ctrl.sv ====
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// [RULE1] Counter runs only while start bit set
// [RULE2] Unused bits 6 and 3 read one
// [RULE3] Bit 5 makes D buffer B
// [RULE4] Bit 4 makes C buffer A
// [RULE5] Bit 2 selects PWM on pin D
// [RULE6] Bit 1 selects PWM on pin C
// [RULE7] Bit 0 selects PWM on pin B
// [RULE8] All defined mode bits reset to zero
// [RULE9] External count clock input accepted
// [RULE10] Pin A compare output or capture input
// [RULE11] Pins B-D compare, capture, or PWM
// [RULE12] Writes to unused bits have no effect
module tmw_mode_ctrl
  import tmw_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // AXI4-Lite write address and data
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  // AXI4-Lite write response
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  // External count clock pin
  input  wire logic        extCountClockIn,
  // Capture/compare pins A..D, index 0 is A
  input  wire logic [3:0]  ccPinIn,
  output var  logic [3:0]  ccPinOut,
  output var  logic [3:0]  ccPinOe,
  // From the compare/capture core
  input  wire logic [3:0]  compareOut,
  input  wire logic [3:0]  pwmOut,
  input  wire logic [3:0]  captureSel,
  input  wire logic        internalCountTick,
  // To the compare/capture core
  output var  logic        counterRun,
  output var  logic        countTick,
  output var  logic        regDBuffersB,
  output var  logic        regCBuffersA,
  output var  logic [3:0]  pwmEnable,
  output var  logic [3:0]  captureIn
);

  function automatic logic isAddr(input logic [31:0] addr, input logic [31:0] offset);
    isAddr = (addr[7:2] == offset[7:2]) && (addr[31:8] == 24'h000000);
  endfunction

  // Mode bits as read back, reserved positions forced high
  function automatic logic [7:0] modeView(input tmw_mode_t m);
    logic [7:0] v;
    v = TMW_MODE_RSV; // RULE2
    v[TMW_START_BIT] = m.startCount;
    v[TMW_BUFB_BIT]  = m.pairBBufEn;
    v[TMW_BUFA_BIT]  = m.pairABufEn;
    v[TMW_PIN_D_PWM_ENABLE_BIT]  = m.pinDPwmEn;
    v[TMW_PIN_C_PWM_ENABLE_BIT]  = m.pinCPwmEn;
    v[TMW_PIN_B_PWM_ENABLE_BIT]  = m.pinBPwmEn;
    modeView = v;
  endfunction

  // Register state
  tmw_mode_t      mode_reg, mode_next;
  logic [7:0]     ctrl_reg, ctrl_next;
  // Bus state
  tmw_bus_state_t wrState_reg, wrState_next;
  tmw_bus_state_t rdState_reg, rdState_next;
  logic           awHeld_reg, awHeld_next;
  logic           wHeld_reg, wHeld_next;
  logic [31:0]    awAddr_reg, awAddr_next;
  logic [31:0]    wData_reg, wData_next;
  logic [3:0]     wStrb_reg, wStrb_next;
  logic [1:0]     bresp_reg, bresp_next;
  logic [31:0]    rdata_reg, rdata_next;
  logic [1:0]     rresp_reg, rresp_next;
  // Pin and core state
  tmw_pins_t      pins_reg, pins_next;
  logic [3:0]     capture_reg, capture_next;
  logic           extSync_reg, extSync_next;
  logic           tick_reg, tick_next;

  logic [7:0]     mergedByte;
  logic           doWrite;

  always_comb
  begin
    awHeld_next  = awHeld_reg;
    wHeld_next   = wHeld_reg;
    awAddr_next  = awAddr_reg;
    wData_next   = wData_reg;
    wStrb_next   = wStrb_reg;
    wrState_next = wrState_reg;
    bresp_next   = bresp_reg;
    mode_next    = mode_reg;
    ctrl_next    = ctrl_reg;
    mergedByte   = 8'h00;
    doWrite      = 1'b0;
    case (wrState_reg)
      TMW_IDLE:
      begin
        if (awvalid && !awHeld_reg)
        begin
          awHeld_next = 1'b1;
          awAddr_next = awaddr;
        end
        if (wvalid && !wHeld_reg)
        begin
          wHeld_next = 1'b1;
          wData_next = wdata;
          wStrb_next = wstrb;
        end
        doWrite = awHeld_reg && wHeld_reg;
        if (doWrite)
        begin
          awHeld_next  = 1'b0;
          wHeld_next   = 1'b0;
          wrState_next = TMW_RESP;
          bresp_next   = TMW_RESP_OKAY;
          if (isAddr(awAddr_reg, TMW_MODE_OFFSET))
          begin
            if (wStrb_reg[0])
            begin
              // Reserved positions are masked off so they never reach state
              mergedByte = wData_reg[7:0] & TMW_MODE_WMASK; // RULE12
              mode_next.startCount = mergedByte[TMW_START_BIT]; // RULE1
              mode_next.pairBBufEn = mergedByte[TMW_BUFB_BIT];  // RULE3
              mode_next.pairABufEn = mergedByte[TMW_BUFA_BIT];  // RULE4
              mode_next.pinDPwmEn  = mergedByte[TMW_PIN_D_PWM_ENABLE_BIT];  // RULE5
              mode_next.pinCPwmEn  = mergedByte[TMW_PIN_C_PWM_ENABLE_BIT];  // RULE6
              mode_next.pinBPwmEn  = mergedByte[TMW_PIN_B_PWM_ENABLE_BIT];  // RULE7
            end
          end
          else if (isAddr(awAddr_reg, TMW_CTRL_OFFSET))
          begin
            if (wStrb_reg[0])
            begin
              ctrl_next = wData_reg[7:0];
            end
          end
          else if (!isAddr(awAddr_reg, TMW_STATUS_OFFSET))
          begin
            bresp_next = TMW_RESP_SLVERR;
          end
        end
      end
      TMW_RESP:
      begin
        if (bready)
        begin
          wrState_next = TMW_IDLE;
        end
      end
      default:
      begin
        wrState_next = TMW_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      mode_reg    <= tmw_mode_t'(TMW_MODE_RESET[5:0]); // RULE8
      ctrl_reg    <= TMW_CTRL_RESET;
      wrState_reg <= TMW_IDLE;
      awHeld_reg  <= 1'b0;
      wHeld_reg   <= 1'b0;
      awAddr_reg  <= 32'h0000_0000;
      wData_reg   <= 32'h0000_0000;
      wStrb_reg   <= 4'h0;
      bresp_reg   <= TMW_RESP_OKAY;
    end
    else
    begin
      mode_reg    <= mode_next;
      ctrl_reg    <= ctrl_next;
      wrState_reg <= wrState_next;
      awHeld_reg  <= awHeld_next;
      wHeld_reg   <= wHeld_next;
      awAddr_reg  <= awAddr_next;
      wData_reg   <= wData_next;
      wStrb_reg   <= wStrb_next;
      bresp_reg   <= bresp_next;
    end
  end

  always_comb
  begin
    rdState_next = rdState_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    case (rdState_reg)
      TMW_IDLE:
      begin
        if (arvalid)
        begin
          rdState_next = TMW_RESP;
          rresp_next   = TMW_RESP_OKAY;
          rdata_next   = 32'h0000_0000;
          if (isAddr(araddr, TMW_MODE_OFFSET))
          begin
            rdata_next = {24'h000000, modeView(mode_reg)}; // RULE2
          end
          else if (isAddr(araddr, TMW_CTRL_OFFSET))
          begin
            rdata_next = {24'h000000, ctrl_reg};
          end
          else if (isAddr(araddr, TMW_STATUS_OFFSET))
          begin
            rdata_next = {23'h000000, extSync_reg, ccPinIn, pins_reg.oe};
          end
          else
          begin
            rresp_next = TMW_RESP_SLVERR;
          end
        end
      end
      TMW_RESP:
      begin
        if (rready)
        begin
          rdState_next = TMW_IDLE;
        end
      end
      default:
      begin
        rdState_next = TMW_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      rdState_reg <= TMW_IDLE;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= TMW_RESP_OKAY;
    end
    else
    begin
      rdState_reg <= rdState_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  // Pin steering and count source
  always_comb
  begin
    pins_next.out    = compareOut;
    pins_next.oe     = ~captureSel; // RULE10
    capture_next     = ccPinIn & captureSel;
    // PWM overrides compare and capture on B..D; A has no PWM mode
    if (mode_reg.pinBPwmEn)
    begin
      pins_next.out[1] = pwmOut[1]; // RULE11
      pins_next.oe[1]  = 1'b1;
      capture_next[1]  = 1'b0;
    end
    if (mode_reg.pinCPwmEn)
    begin
      pins_next.out[2] = pwmOut[2]; // RULE11
      pins_next.oe[2]  = 1'b1;
      capture_next[2]  = 1'b0;
    end
    if (mode_reg.pinDPwmEn)
    begin
      pins_next.out[3] = pwmOut[3]; // RULE11
      pins_next.oe[3]  = 1'b1;
      capture_next[3]  = 1'b0;
    end
    extSync_next = extCountClockIn;
    // Rising edge of the external clock counts; only while started
    if (ctrl_reg[TMW_EXTCLK_SEL_BIT])
    begin
      tick_next = mode_reg.startCount && extCountClockIn && !extSync_reg; // RULE9
    end
    else
    begin
      tick_next = mode_reg.startCount && internalCountTick; // RULE1
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      pins_reg    <= '0;
      capture_reg <= 4'h0;
      extSync_reg <= 1'b0;
      tick_reg    <= 1'b0;
    end
    else
    begin
      pins_reg    <= pins_next;
      capture_reg <= capture_next;
      extSync_reg <= extSync_next;
      tick_reg    <= tick_next;
    end
  end

  assign awready      = (wrState_reg == TMW_IDLE) && !awHeld_reg;
  assign wready       = (wrState_reg == TMW_IDLE) && !wHeld_reg;
  assign bvalid       = (wrState_reg == TMW_RESP);
  assign bresp        = bresp_reg;
  assign arready      = (rdState_reg == TMW_IDLE);
  assign rvalid       = (rdState_reg == TMW_RESP);
  assign rdata        = rdata_reg;
  assign rresp        = rresp_reg;
  assign ccPinOut     = pins_reg.out;
  assign ccPinOe      = pins_reg.oe;
  assign captureIn    = capture_reg;
  assign counterRun   = mode_reg.startCount; // RULE1
  assign countTick    = tick_reg;
  assign regDBuffersB = mode_reg.pairBBufEn; // RULE3
  assign regCBuffersA = mode_reg.pairABufEn; // RULE4
  assign pwmEnable    = {mode_reg.pinDPwmEn, mode_reg.pinCPwmEn, mode_reg.pinBPwmEn, 1'b0};

endmodule

`default_nettype wire

// ==== src/tmw_pkg.sv ====
package tmw_pkg;

  // Register map
  localparam logic [31:0] TMW_MODE_OFFSET   = 32'h0000_0000;
  localparam logic [31:0] TMW_CTRL_OFFSET   = 32'h0000_0004;
  localparam logic [31:0] TMW_STATUS_OFFSET = 32'h0000_0008;

  // Mode register field positions
  localparam int TMW_START_BIT = 7;
  localparam int TMW_RSV6_BIT  = 6;
  localparam int TMW_BUFB_BIT  = 5;
  localparam int TMW_BUFA_BIT  = 4;
  localparam int TMW_RSV3_BIT  = 3;
  localparam int TMW_PIN_D_PWM_ENABLE_BIT  = 2;
  localparam int TMW_PIN_C_PWM_ENABLE_BIT  = 1;
  localparam int TMW_PIN_B_PWM_ENABLE_BIT  = 0;

  // Writable bits, reserved bits, reset value
  localparam logic [7:0] TMW_MODE_WMASK = 8'hB7;
  localparam logic [7:0] TMW_MODE_RSV   = 8'h48;
  localparam logic [7:0] TMW_MODE_RESET = 8'h00;
  localparam logic [7:0] TMW_CTRL_RESET = 8'h00;

  // Control register field positions
  localparam int TMW_EXTCLK_SEL_BIT = 0;

  localparam logic [1:0] TMW_RESP_OKAY   = 2'h0;
  localparam logic [1:0] TMW_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic startCount;
    logic pairABufEn;
    logic pairBBufEn;
    logic pinBPwmEn;
    logic pinCPwmEn;
    logic pinDPwmEn;
  } tmw_mode_t;

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } tmw_pins_t;

  typedef enum logic [1:0] {
    TMW_IDLE = 2'b01,
    TMW_RESP = 2'b10
  } tmw_bus_state_t;

endpackage

// ==== verification/tmw_mode_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none

module tmw_mode_monitor
  import tmw_pkg::*;
(
  // Clock, reset, bus answer
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       bvalid,
  // Pins
  input wire logic       extCountClockIn,
  input wire logic [3:0] ccPinIn,
  input wire logic [3:0] ccPinOut,
  input wire logic [3:0] ccPinOe,
  // Core side
  input wire logic [3:0] compareOut,
  input wire logic [3:0] pwmOut,
  input wire logic [3:0] captureSel,
  input wire logic       internalCountTick,
  input wire logic       counterRun,
  input wire logic       countTick,
  input wire logic       regDBuffersB,
  input wire logic       regCBuffersA,
  input wire logic [3:0] pwmEnable,
  input wire logic [3:0] captureIn
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  // External rise may be seen one or two samples late
  a_tick_cause: assert property (countTick |-> $past(internalCountTick)
    || ($past(extCountClockIn) && !$past(extCountClockIn, 2))
    || ($past(extCountClockIn, 2) && !$past(extCountClockIn, 3)))
    else $error("count tick without a source edge");
  a_tick_gated: assert property (countTick |-> counterRun || $past(counterRun))
    else $error("count tick while stopped");
  // Mode bits move on the very edge that raises bvalid
  a_mode_commit: assert property ($changed({counterRun, regDBuffersB, regCBuffersA,
    pwmEnable}) |-> $rose(bvalid))
    else $error("mode output moved without a write");
  // Pin steering is registered, so it follows the mode one cycle late
  a_pwm_pin_b: assert property ($past(pwmEnable[1]) |-> ccPinOe[1]
    && ccPinOut[1] == $past(pwmOut[1])) else $error("pin B not driving PWM");
  a_pwm_pin_c: assert property ($past(pwmEnable[2]) |-> ccPinOe[2]
    && ccPinOut[2] == $past(pwmOut[2])) else $error("pin C not driving PWM");
  a_pwm_pin_d: assert property ($past(pwmEnable[3]) |-> ccPinOe[3]
    && ccPinOut[3] == $past(pwmOut[3])) else $error("pin D not driving PWM");
  a_capture_masked: assert property ((captureIn & $past(pwmEnable)) == 4'h0)
    else $error("capture seen on a PWM pin");
  a_pin_a_path: assert property ($past(rstn) |-> !pwmEnable[0]
    && captureIn[0] == $past(ccPinIn[0] & captureSel[0])
    && ccPinOe[0] == !$past(captureSel[0])
    && (!ccPinOe[0] || ccPinOut[0] == $past(compareOut[0])))
    else $error("pin A path wrong");
endmodule

bind tmw_mode_ctrl tmw_mode_monitor u_mon (.mclk, .rstn, .bvalid, .extCountClockIn, .ccPinIn,
  .ccPinOut, .ccPinOe, .compareOut, .pwmOut, .captureSel, .internalCountTick, .counterRun,
  .countTick, .regDBuffersB, .regCBuffersA, .pwmEnable, .captureIn);

`default_nettype wire

// ==== verification/tmw_pin_load.sv ====
`timescale 1ns/100ps
`default_nettype none

module tmw_pin_load
(
  // Device drive
  input wire logic [3:0] ccPinOut,
  input wire logic [3:0] ccPinOe,
  // Outside sources
  input wire logic [3:0] srcLevel,
  output var logic [3:0] ccPinIn
);
  // A released pin shows whatever the outside source puts on it
  assign ccPinIn = (ccPinOe & ccPinOut) | (~ccPinOe & srcLevel);
endmodule

`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import tmw_pkg::*;
;
  logic        mclk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, extCountClockIn, internalCountTick;
  logic        counterRun, countTick, regDBuffersB, regCBuffersA, s;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [1:0]  bresp, rresp;
  logic [3:0]  wstrb, ccPinIn, ccPinOut, ccPinOe, compareOut, pwmOut, captureSel;
  logic [3:0]  pwmEnable, captureIn, srcLevel;
  logic [7:0]  m, d;
  logic [33:0] eq[$];
  int          errors, total_checks;

  tmw_mode_ctrl u_dut (.mclk, .rstn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .extCountClockIn, .ccPinIn, .ccPinOut, .ccPinOe, .compareOut, .pwmOut,
    .captureSel, .internalCountTick, .counterRun, .countTick, .regDBuffersB, .regCBuffersA,
    .pwmEnable, .captureIn);
  tmw_pin_load u_load (.ccPinOut, .ccPinOe, .srcLevel, .ccPinIn);

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("FAIL %0t got %h want %h", $time, g, e);
    end
  endtask

  task automatic rst;
    rstn <= 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
  endtask

  // Upper data bits are random: only the low byte is stored
  task automatic wr(input logic [31:0] a, input logic [7:0] v, input logic [1:0] r);
    eq.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= {24'($urandom), v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
  endtask

  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    eq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
  endtask

  // Outputs are read at an edge before the design updates them
  task automatic tick(input logic ext, input logic x);
    if (ext) extCountClockIn <= 1'b1;
    else internalCountTick <= 1'b1;
    @(posedge mclk);
    internalCountTick <= 1'b0;
    @(posedge mclk);
    s = countTick;
    extCountClockIn <= 1'b0;
    @(posedge mclk);
    s = s | countTick;
    chk({33'h0, s}, {33'h0, x});
  endtask

  always @(posedge mclk)
  begin
    compareOut <= 4'($urandom);
    pwmOut <= 4'($urandom);
    captureSel <= 4'($urandom);
    srcLevel <= 4'($urandom);
    if (bvalid || rvalid) chk(bvalid ? {bresp, 32'h0} : {rresp, rdata}, eq.pop_front());
  end

  initial
  begin
    #40000;
    errors++;
    stop_test();
  end

  initial
  begin
    void'($urandom(67299));
    {rstn, awvalid, wvalid, arvalid, extCountClockIn, internalCountTick} = 6'h0;
    {bready, rready, wstrb, awaddr, wdata, araddr} = {2'h3, 4'hF, 96'h0};
    {compareOut, pwmOut, captureSel, srcLevel} = 16'h0;
    errors = 0;
    total_checks = 0;
    rst();
    rd(TMW_MODE_OFFSET, {TMW_RESP_OKAY, 24'h0, TMW_MODE_RSV});
    chk({27'h0, counterRun, regDBuffersB, regCBuffersA, pwmEnable}, 34'h0);
    for (int i = 0; i < 16; i++)
    begin
      d = (i < 8) ? 8'h01 << i : 8'($urandom);
      m = (d & TMW_MODE_WMASK) | TMW_MODE_RSV;
      wr(TMW_MODE_OFFSET, d, TMW_RESP_OKAY);
      @(posedge mclk);
      chk({27'h0, counterRun, regDBuffersB, regCBuffersA, pwmEnable},
        {27'h0, m[7], m[5], m[4], m[2], m[1], m[0], 1'b0});
      rd(TMW_MODE_OFFSET, {TMW_RESP_OKAY, 24'h0, m});
    end
    for (int j = 0; j < 8; j++)
    begin
      wr(TMW_MODE_OFFSET, {j[2], 7'h0}, TMW_RESP_OKAY);
      wr(TMW_CTRL_OFFSET, {7'h0, j[1]}, TMW_RESP_OKAY);
      tick(j[0], j[2] && (j[1] == j[0]));
    end
    wr(32'h0000_000C, 8'hFF, TMW_RESP_SLVERR);
    rd(32'h0000_000C, {TMW_RESP_SLVERR, 32'h0});
    // Status writes and writes without the low strobe leave the mode alone
    wr(TMW_STATUS_OFFSET, 8'hFF, TMW_RESP_OKAY);
    wstrb <= 4'hE;
    wr(TMW_MODE_OFFSET, 8'hFF, TMW_RESP_OKAY);
    wstrb <= 4'hF;
    rd(TMW_MODE_OFFSET, {TMW_RESP_OKAY, 24'h0, 8'h80 | TMW_MODE_RSV});
    wr(TMW_MODE_OFFSET, 8'hFF, TMW_RESP_OKAY);
    rst();
    rd(TMW_MODE_OFFSET, {TMW_RESP_OKAY, 24'h0, TMW_MODE_RSV});
    stop_test();
  end
endmodule

`default_nettype wire
